// >>> rtl/fbbp_pkg.sv
// package: register map, reset values and widths of the four-bit port
package fbbp_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFF_PIN_DATA = 4'h0;
    localparam logic [3:0] OFF_DIRECTION = 4'h4;
    localparam logic [3:0] OFF_ANALOG_SEL = 4'h8;
    localparam logic [3:0] OFF_CONFIG = 4'hc;
    localparam int PORT_W = 4;
    localparam int PIN3_POS = 3;
    localparam int ANALOG_PINS = 3;
    localparam logic [3:0] DIRECTION_RESET = 4'hf;
    localparam logic [7:0] ANALOG_SEL_RESET = 8'hff;
    localparam logic [3:0] LATCH_RESET = 4'h0;
    localparam int CFG_MASTER_CLEAR_POS = 0;
    localparam logic CFG_MASTER_CLEAR_RESET = 1'b1;
    localparam int SYNC_STAGES = 2;
endpackage

// >>> rtl/fbbp_sync.sv
// two-flop synchroniser for the pin inputs
`timescale 1ns/1ps
module fbbp_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk,              // system clock
    input wire logic ce,               // clock enable
    input wire logic [WIDTH-1:0] d,    // asynchronous input
    output logic [WIDTH-1:0] q         // synchronised output
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // no reset: levels settle within two cycles anyway
    always_ff @(posedge clk) begin
        if (ce) begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule // fbbp_sync

// >>> rtl/fbbp_port.sv
// four-bit bidirectional port with direction, latch and analog select
//
// Operation
// - The port has four pins, three of them two-way, each with one data bit and one direction bit.
// - A direction bit of one turns the pin's driver off so the pin is an input.
// - A direction bit of zero enables the driver and puts the output latch on the pin.
// - Pin 3 never drives and its direction bit always reads one.
// - Reading the data register returns sampled pin levels, not the latches.
// - A data write loads all four latches straight from the write data; the pins are not sampled.
// - With master clear enabled, pin 3's data bit reads zero.
// - Direction bits still steer drivers on analog pins; software should keep them set.
// - A pin selected as analog reads zero in the data register.
// - A data bit reads one for a high pin level and zero for a low one.
// - Power-on or brown-out sets direction to all ones; other resets keep the latches.
// - Bits 7 to 4 of data and direction read zero.
// - Pin 3 is a plain input or the master-clear input with a weak pull-up.
// - Pins 0 to 2 are each digital I/O or an analog converter input.
`timescale 1ns/1ps
module fbbp_port (
    input wire logic MCLK,             // system clock, 250 MHz
    input wire logic RESET_N,          // synchronous reset, any source
    input wire logic POR_N,            // power-on or brown-out reset, synchronous
    input wire logic CE,               // clock enable, freezes all state except the two resets, which still act while it is low
    input wire logic [3:0] ADDR,       // register byte address
    input wire logic [7:0] WDATA,      // write data
    input wire logic WR,               // write strobe
    input wire logic RD,               // read strobe
    output logic [7:0] RDATA,          // read data, cycle after read strobe
    input wire logic [3:0] PIN_IN,     // pin levels from pads
    output logic [3:0] PIN_OUT,        // pin drive values
    output logic [3:0] PIN_OE,         // pin drive enables, high drives
    output logic PIN3_PULLUP,          // weak pull-up enable on pin 3
    output logic MASTER_CLEAR_RESET,   // reset request from pin 3, high active
    output logic [2:0] ANALOG_ROUTE    // pins routed to the converter
);
    logic [3:0] pins_sync;
    logic [3:0] latch_reg;
    logic [3:0] direction_reg;
    logic [7:0] analog_sel_reg;
    logic master_clear_enable_reg;
    logic [7:0] rdata_reg;
    logic [3:0] pin_data_view;
    logic [3:0] analog_mask;

    fbbp_sync #(.WIDTH(fbbp_pkg::PORT_W)) u_sync (
        .clk(MCLK),
        .ce(CE),
        .d(PIN_IN),
        .q(pins_sync)
    );

    // shared decode for each register select
    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        return a == off;
    endfunction

    // pins 0-2 can be analog; pin 3 never
    assign analog_mask = {1'b0, analog_sel_reg[fbbp_pkg::ANALOG_PINS-1:0]};

    // live levels with analog pins and master-clear pin masked to zero
    always_comb begin
        pin_data_view = pins_sync & ~analog_mask;
        if (master_clear_enable_reg) begin
            pin_data_view[fbbp_pkg::PIN3_POS] = 1'b0;
        end
    end

    // latches survive every reset but power-on/brown-out, which clears them
    always_ff @(posedge MCLK) begin
        if (!POR_N) begin
            latch_reg <= fbbp_pkg::LATCH_RESET;
        end else if (CE && WR && hit(ADDR, fbbp_pkg::OFF_PIN_DATA)) begin
            // a byte write addresses all four bits, so the pin sample drops out
            latch_reg <= WDATA[3:0];
        end
    end

    always_ff @(posedge MCLK) begin
        if (!POR_N || !RESET_N) begin
            direction_reg <= fbbp_pkg::DIRECTION_RESET;
        end else if (CE && WR && hit(ADDR, fbbp_pkg::OFF_DIRECTION)) begin
            direction_reg <= WDATA[3:0] | 4'h8;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!POR_N || !RESET_N) begin
            analog_sel_reg <= fbbp_pkg::ANALOG_SEL_RESET;
        end else if (CE && WR && hit(ADDR, fbbp_pkg::OFF_ANALOG_SEL)) begin
            analog_sel_reg <= WDATA;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!POR_N) begin
            master_clear_enable_reg <= fbbp_pkg::CFG_MASTER_CLEAR_RESET;
        end else if (CE && WR && hit(ADDR, fbbp_pkg::OFF_CONFIG)) begin
            master_clear_enable_reg <= WDATA[fbbp_pkg::CFG_MASTER_CLEAR_POS];
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge MCLK) begin
        if (!RESET_N || !POR_N) begin
            rdata_reg <= 8'h00;
        end else if (CE) begin
            if (RD) begin
                unique case (ADDR)
                    fbbp_pkg::OFF_PIN_DATA: rdata_reg <= {4'h0, pin_data_view};
                    fbbp_pkg::OFF_DIRECTION: rdata_reg <= {4'h0, direction_reg};
                    fbbp_pkg::OFF_ANALOG_SEL: rdata_reg <= analog_sel_reg;
                    fbbp_pkg::OFF_CONFIG: rdata_reg <= {7'h00, master_clear_enable_reg};
                    default: rdata_reg <= 8'h00;
                endcase
            end else begin
                rdata_reg <= 8'h00;
            end
        end
    end

    assign RDATA = rdata_reg;

    // drivers follow direction even on analog pins; pin 3 is never driven
    genvar g;
    generate
        for (g = 0; g < fbbp_pkg::PORT_W; g++) begin : g_pad
            if (g == fbbp_pkg::PIN3_POS) begin : g_in_only
                assign PIN_OE[g] = 1'b0;
                assign PIN_OUT[g] = 1'b0;
            end else begin : g_bidir
                assign PIN_OE[g] = ~direction_reg[g];
                assign PIN_OUT[g] = latch_reg[g];
            end
        end
    endgenerate

    assign PIN3_PULLUP = master_clear_enable_reg;
    // pin 3 low with master clear enabled asks for a reset
    assign MASTER_CLEAR_RESET = master_clear_enable_reg & ~pins_sync[fbbp_pkg::PIN3_POS];
    assign ANALOG_ROUTE = analog_sel_reg[fbbp_pkg::ANALOG_PINS-1:0];
endmodule // fbbp_port

// >>> verification/fbbp_monitor.sv
// checker of the four-bit port seen from its top-level ports
`timescale 1ns/1ps
module fbbp_monitor (
    input wire logic MCLK, RESET_N, POR_N, CE, WR, RD, // clock, resets, strobes
    input wire logic [3:0] ADDR, PIN_IN, PIN_OUT, PIN_OE, // address and pins
    input wire logic [7:0] WDATA, RDATA, // bus data
    input wire logic PIN3_PULLUP, MASTER_CLEAR_RESET, // pin 3 function
    input wire logic [2:0] ANALOG_ROUTE // converter routing
);
    localparam logic [3:0] AD = fbbp_pkg::OFF_PIN_DATA, AR = fbbp_pkg::OFF_DIRECTION;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    sequence wr_s(logic [3:0] a); WR && CE && ADDR == a; endsequence
    sequence rd_s(logic [3:0] a); RD && CE && ADDR == a; endsequence
    dir_drive_a: assert property (wr_s(AR) |=>
        PIN_OE == (4'(~$past(WDATA)) & 4'h7)) else $error("bad drive enable");
    dat_latch_a: assert property (wr_s(AD) |=>
        PIN_OUT[2:0] == 3'($past(WDATA))) else $error("bad pin drive value");
    ana_route_a: assert property (wr_s(fbbp_pkg::OFF_ANALOG_SEL) |=>
        ANALOG_ROUTE == 3'($past(WDATA))) else $error("bad analog route");
    pullup_cfg_a: assert property (wr_s(fbbp_pkg::OFF_CONFIG) |=>
        PIN3_PULLUP == 1'($past(WDATA))) else $error("bad pull-up");
    hi_zero_a: assert property (rd_s(AD) or rd_s(AR) |=> RDATA[7:4] == 4'h0)
        else $error("upper bits set");
    pin3_read_a: assert property (rd_s(AD) and PIN3_PULLUP |=> !RDATA[3])
        else $error("pin 3 reads high");
    pin3_quiet_a: assert property (PIN_OE[3] == 1'b0 && PIN_OUT[3] == 1'b0)
        else $error("pin 3 driven");
    clear_req_a: assert property ($past(CE) && $past(CE, 2) |->
        MASTER_CLEAR_RESET == (PIN3_PULLUP && !$past(PIN_IN[3], 2)))
        else $error("bad master-clear request");
    ce_freeze_a: assert property (!CE && POR_N |=> $stable(PIN_OE) && $stable(PIN_OUT)
        && $stable(ANALOG_ROUTE) && $stable(PIN3_PULLUP)) else $error("state moved with enable low");
    ana_read_a: assert property (rd_s(AD) |=>
        (RDATA[2:0] & $past(ANALOG_ROUTE)) == 3'h0) else $error("analog pin reads high");
    por_safe_a: assert property (!POR_N |=> PIN_OE == 4'h0 && ANALOG_ROUTE == 3'h7)
        else $error("bad power-on state");
endmodule // fbbp_monitor

// >>> verification/fbbp_pads.sv
// outside circuitry: drives every pin that the port leaves free
`timescale 1ns/1ps
module fbbp_pads (
    input wire logic [3:0] PIN_OUT, PIN_OE, EXT, // drive, enable, outside level
    output logic [3:0] PIN_IN // resolved pad level
);
    assign PIN_IN = (PIN_OE & PIN_OUT) | (~PIN_OE & EXT);
endmodule // fbbp_pads

// >>> verification/tb.sv
// self-checking bench: register traffic against a modelled pin level
`timescale 1ns/1ps
module tb;
    localparam logic [3:0] AD = fbbp_pkg::OFF_PIN_DATA, AR = fbbp_pkg::OFF_DIRECTION;
    localparam logic [3:0] AA = fbbp_pkg::OFF_ANALOG_SEL, AC = fbbp_pkg::OFF_CONFIG;
    logic mclk = 0, reset_n = 0, por_n = 0, wr = 0, rd = 0, rd_q = 0, ce = 1, pull, clear_req, mc;
    logic [3:0] addr = 4'h0, ext = 4'h0, pin_in, pin_out, pin_oe;
    logic [7:0] wdata = 8'h00, rdata, dir, dat, ana, exp_q[$];
    logic [2:0] route, p;
    int num_errors = 0, samples_checked = 0, seed = 71;
    fbbp_port DUT (.MCLK(mclk), .RESET_N(reset_n), .POR_N(por_n), .CE(ce), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out),
        .PIN_OE(pin_oe), .PIN3_PULLUP(pull), .MASTER_CLEAR_RESET(clear_req), .ANALOG_ROUTE(route));
    fbbp_pads pads (.PIN_OUT(pin_out), .PIN_OE(pin_oe), .EXT(ext), .PIN_IN(pin_in));
    initial forever #2 mclk = ~mclk;
    // one edge per call, so back-to-back strobes never assign twice
    task automatic op(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        {wr, rd, addr, wdata} <= {w, !w, a, d};
        if (!w) exp_q.push_back(d);
    endtask
    task automatic nop(input int n);
        repeat (n) @(posedge mclk) {wr, rd} <= 2'b00;
    endtask
    task automatic cmp(input logic [7:0] g, input logic [7:0] x);
        samples_checked++;
        if (g !== x) begin
            num_errors++;
            $display("unexpected read at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    always @(posedge mclk) rd_q <= rd;
    always @(negedge mclk) if (rd_q) cmp(rdata, exp_q.pop_front());
    task automatic stop_test;
        $display("reads checked %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        num_errors++;
        stop_test;
    end
    initial begin
        repeat (16) @(posedge mclk);
        {reset_n, por_n} <= 2'b11;
        op(0, AR, 8'h0f);
        op(0, AA, 8'hff);
        op(0, 4'h2, 8'h00); // unmapped place reads zero
        repeat (24) begin
            {dir, dat, ana} = 24'($random(seed));
            mc = 1'($random(seed));
            ext <= 4'($random(seed));
            op(1, AC, {7'h00, mc});
            op(1, AA, ana);
            op(1, AR, dir);
            op(1, AD, dat);
            // enable low at this write's edge: direction must keep dir
            op(1, AR, ~dir);
            ce <= 1'b0;
            nop(1);
            ce <= 1'b1;
            nop(3);
            p = (~dir[2:0] & dat[2:0] | dir[2:0] & ext[2:0]) & ~ana[2:0];
            op(0, AD, {4'h0, ~mc & ext[3], p});
            op(0, AR, {5'h01, dir[2:0]});
            op(0, AA, ana);
        end
        // let the last read land before reset clears the read data
        nop(1);
        reset_n <= 1'b0;
        nop(2);
        reset_n <= 1'b1;
        op(0, AR, 8'h0f);
        op(1, AA, 8'h00);
        op(1, AR, 8'h00);
        nop(4);
        op(0, AD, {4'h0, ~mc & ext[3], dat[2:0]});
        nop(1);
        por_n <= 1'b0;
        nop(2);
        por_n <= 1'b1;
        op(0, AC, 8'h01);
        op(0, AR, 8'h0f);
        op(0, AA, 8'hff);
        nop(2);
        stop_test;
    end
endmodule // tb
bind fbbp_port fbbp_monitor mon (.MCLK(MCLK), .RESET_N(RESET_N), .POR_N(POR_N), .CE(CE),
    .WR(WR), .RD(RD), .ADDR(ADDR), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
    .WDATA(WDATA), .RDATA(RDATA), .PIN3_PULLUP(PIN3_PULLUP),
    .MASTER_CLEAR_RESET(MASTER_CLEAR_RESET), .ANALOG_ROUTE(ANALOG_ROUTE));
